// *** spm_port.sv ***
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "spm_map.svh"

// Functional notes
// - slave with select low drives miso if enabled
// - slave with select high ignores everything
// - select rising resets slave counters immediately
// - master with select output: plain output
// - master, select input low: drop to slave
// - forced drop also sets transfer-done flag
// - irq needs enable, done flag, global enable
// - enable bit gates all port activity except the select pin drive
// - order bit one shifts lsb first
// - role bit one selects master
// - idle level bit sets sck idle
// - phase bit chooses sample edge
// - rate bits divide clock in master only
// - finished byte sets transfer-done flag
// - vector acknowledge clears transfer-done flag
// - status read then data access clears flag
// - data write while busy sets collision
// - collision read then data access clears both
// - status bits five to one read zero
// - double-speed bit halves master sck period
// - master data write starts transfer, read returns byte
// - single transmit buffer, double receive buffer
module spm_port
	import spm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_global_irq_en,
	input  wire logic        i_irq_ack,
	output logic             o_irq,
	input  wire logic        i_sck,
	output logic             o_sck,
	output logic             o_sck_oe,
	input  wire logic        i_mosi,
	output logic             o_mosi,
	output logic             o_mosi_oe,
	input  wire logic        i_miso,
	output logic             o_miso,
	output logic             o_miso_oe,
	input  wire logic        i_ss,
	output logic             o_ss,
	output logic             o_ss_oe
);

	spm_byte_t  port_control_reg;
	spm_byte_t  pin_cfg;
	spm_byte_t  shift_data_reg;
	spm_byte_t  rx_buf;
	spm_state_t state;
	logic       transfer_done_flag;
	logic       write_collision_flag;
	logic       double_speed_bit;
	logic       arm_done;
	logic       arm_write_collision_flag;
	logic [6:0] half_cnt;
	logic [4:0] edge_cnt;
	logic [3:0] bit_cnt;
	logic       sck_drv;
	logic       out_bit;

	logic [3:0] s1, s2, s3, pin_f, pin_prev;

	function automatic logic tx_bit(input spm_byte_t b, input logic lsb_first);
		tx_bit = lsb_first ? b[0] : b[7];
	endfunction

	function automatic logic [6:0] half_of(input logic [2:0] sel);
		case (sel)
			3'h0: half_of = `SPM_HALF_DIV4;
			3'h1: half_of = `SPM_HALF_DIV16;
			3'h2: half_of = `SPM_HALF_DIV64;
			3'h3: half_of = `SPM_HALF_DIV128;
			3'h4: half_of = `SPM_HALF_DIV2;
			3'h5: half_of = `SPM_HALF_DIV8;
			3'h6: half_of = `SPM_HALF_DIV32;
			default: half_of = `SPM_HALF_DIV64X;
		endcase
	endfunction

	// field views
	logic ie, en, lsb_first, master_select_bit, clock_idle_level, clock_phase_select;
	assign ie                = port_control_reg[`SPM_CTL_IE];
	assign en                = port_control_reg[`SPM_CTL_EN];
	assign lsb_first         = port_control_reg[`SPM_CTL_ORDER];
	assign master_select_bit = port_control_reg[`SPM_CTL_MASTER];
	assign clock_idle_level              = port_control_reg[`SPM_CTL_CLOCK_IDLE_LEVEL];
	assign clock_phase_select              = port_control_reg[`SPM_CTL_CLOCK_PHASE_SELECT];

	// pin inputs: three stages, a change counts once stages two and three agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1       <= `SPM_PIN_IDLE;
			s2       <= `SPM_PIN_IDLE;
			s3       <= `SPM_PIN_IDLE;
			pin_f    <= `SPM_PIN_IDLE;
			pin_prev <= `SPM_PIN_IDLE;
		end else begin
			s1       <= {i_ss, i_sck, i_mosi, i_miso};
			s2       <= s1;
			s3       <= s2;
			pin_f    <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & pin_f);
			pin_prev <= pin_f;
		end
	end

	logic ss_f, sck_f, mosi_f, miso_f;
	assign {ss_f, sck_f, mosi_f, miso_f} = pin_f;

	// APB decode; zero wait states
	logic access, wr, rd, hit_ctl, hit_sts, hit_dat, hit_pin, mapped;
	assign access  = i_psel & i_penable;
	assign hit_ctl = (i_paddr == `SPM_OFF_CONTROL);
	assign hit_sts = (i_paddr == `SPM_OFF_STATUS);
	assign hit_dat = (i_paddr == `SPM_OFF_DATA);
	assign hit_pin = (i_paddr == `SPM_OFF_PINCFG);
	assign mapped  = hit_ctl | hit_sts | hit_dat | hit_pin;
	assign wr      = access & i_pwrite & i_pstrb[0] & mapped;
	assign rd      = access & ~i_pwrite & mapped;
	assign o_pready  = 1'b1;
	assign o_pslverr = access & ~mapped;

	// role and event terms
	logic is_master, slave_act, busy, force_slave, ss_rise;
	logic m_tick, edge_ev, is_lead, sample_ev, setup_ev, in_bit, done_ev;
	logic data_wr, data_acc, start, last_edge;
	spm_byte_t sr_shift;

	assign is_master   = en & master_select_bit;
	assign slave_act   = en & ~master_select_bit & ~ss_f;
	assign busy        = (state == SPM_SHIFT);
	// select pin as input pulled low by another master
	assign force_slave = is_master & ~pin_cfg[`SPM_PIN_SS_DIR] & ~ss_f;
	assign ss_rise     = en & ~master_select_bit & ss_f & ~pin_prev[3];
	assign m_tick      = is_master & busy
	                   & (half_cnt == half_of({double_speed_bit, port_control_reg[1:0]}) - 7'd1);
	// slave edges only count while selected; a deselected slave ignores sck
	assign edge_ev     = is_master ? m_tick
	                   : slave_act & (sck_f ^ pin_prev[2]);
	assign is_lead     = is_master ? ~edge_cnt[0] : (sck_f ^ clock_idle_level);
	assign sample_ev   = edge_ev & (is_lead ^ clock_phase_select);
	assign setup_ev    = edge_ev & ~(is_lead ^ clock_phase_select);
	assign in_bit      = is_master ? miso_f : mosi_f;
	assign sr_shift    = lsb_first ? {in_bit, shift_data_reg[7:1]}
	                   : {shift_data_reg[6:0], in_bit};
	assign last_edge   = (edge_cnt == `SPM_LAST_EDGE);
	assign done_ev     = is_master ? (m_tick & last_edge)
	                   : (sample_ev & (bit_cnt == `SPM_LAST_BIT));
	assign data_wr     = wr & hit_dat;
	assign data_acc    = access & hit_dat;
	assign start       = data_wr & ~busy & is_master;

	// control register; forced fall-back overrides a same-cycle write
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			port_control_reg <= `SPM_CTL_RESET;
		end else begin
			if (wr && hit_ctl) begin
				port_control_reg <= i_pwdata[7:0];
			end
			if (force_slave) begin
				port_control_reg[`SPM_CTL_MASTER] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_cfg <= `SPM_PIN_RESET;
		end else if (wr && hit_pin) begin
			pin_cfg <= {3'h0, i_pwdata[4:0]};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			double_speed_bit <= 1'(`SPM_STS_RESET >> `SPM_STS_X2);
		end else if (wr && hit_sts) begin
			double_speed_bit <= i_pwdata[`SPM_STS_X2];
		end
	end

	// status flags: a set in the same cycle as a clear wins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			arm_done <= 1'b0;
			arm_write_collision_flag <= 1'b0;
		end else if (rd && hit_sts) begin
			arm_done <= transfer_done_flag;
			arm_write_collision_flag <= write_collision_flag;
		end else if (data_acc) begin
			arm_done <= 1'b0;
			arm_write_collision_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			transfer_done_flag <= 1'b0;
		end else if (done_ev || force_slave) begin
			transfer_done_flag <= 1'b1;
		end else if (i_irq_ack || (data_acc && (arm_done || arm_write_collision_flag))) begin
			transfer_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			write_collision_flag <= 1'b0;
		end else if (data_wr && busy) begin
			write_collision_flag <= 1'b1;
		end else if (data_acc && arm_write_collision_flag) begin
			write_collision_flag <= 1'b0;
		end
	end

	assign o_irq = ie & transfer_done_flag & i_global_irq_en;

	// transfer engine: shared by both roles
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state    <= SPM_IDLE;
			half_cnt <= 7'h00;
			edge_cnt <= 5'h00;
			bit_cnt  <= 4'h0;
		end else if (!en || force_slave || ss_rise) begin
			state    <= SPM_IDLE;
			half_cnt <= 7'h00;
			edge_cnt <= 5'h00;
			bit_cnt  <= 4'h0;
		end else if (start) begin
			state    <= SPM_SHIFT;
			half_cnt <= 7'h00;
			edge_cnt <= 5'h00;
			bit_cnt  <= 4'h0;
		end else begin
			if (is_master && busy) begin
				half_cnt <= m_tick ? 7'h00 : half_cnt + 7'd1;
			end
			if (edge_ev) begin
				edge_cnt <= edge_cnt + 5'd1;
				// a trailing setup edge after the last sample must not reopen a byte,
				// or a data write between bytes would count as a collision
				if (!is_master && (sample_ev || clock_phase_select)) begin
					state <= SPM_SHIFT;
				end
			end
			if (sample_ev) begin
				bit_cnt <= bit_cnt + 4'd1;
			end
			if (done_ev) begin
				state    <= SPM_IDLE;
				edge_cnt <= 5'h00;
				bit_cnt  <= 4'h0;
			end
		end
	end

	// shift register is the single transmit buffer; writes while busy are dropped
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			shift_data_reg <= 8'h00;
		end else if (data_wr && !busy) begin
			shift_data_reg <= i_pwdata[7:0];
		end else if (sample_ev) begin
			shift_data_reg <= sr_shift;
		end
	end

	// receive buffer holds the last full byte until the next one lands
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_buf <= 8'h00;
		end else if (done_ev) begin
			rx_buf <= sample_ev ? sr_shift : shift_data_reg;
		end
	end

	// outgoing data bit: first bit parked while idle so phase 0 has it ready
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_bit <= 1'b0;
		end else if (start) begin
			out_bit <= tx_bit(i_pwdata[7:0], lsb_first);
		end else if (!busy && !edge_ev) begin
			out_bit <= tx_bit(shift_data_reg, lsb_first);
		end else if (setup_ev) begin
			out_bit <= tx_bit(shift_data_reg, lsb_first);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sck_drv <= 1'b0;
		end else if (!is_master || !busy) begin
			sck_drv <= clock_idle_level;
		end else if (m_tick) begin
			sck_drv <= ~sck_drv;
		end
	end

	// APB read data registered in the setup phase; reserved status bits are zero
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable) begin
			if (i_paddr == `SPM_OFF_CONTROL) begin
				o_prdata <= {24'h00_0000, port_control_reg};
			end else if (i_paddr == `SPM_OFF_STATUS) begin
				o_prdata <= {24'h00_0000, transfer_done_flag, write_collision_flag,
				             5'h00, double_speed_bit};
			end else if (i_paddr == `SPM_OFF_DATA) begin
				o_prdata <= {24'h00_0000, rx_buf};
			end else if (i_paddr == `SPM_OFF_PINCFG) begin
				o_prdata <= {24'h00_0000, pin_cfg};
			end else begin
				o_prdata <= 32'h0000_0000;
			end
		end
	end

	// pin drive; a disabled port leaves sck, mosi and miso undriven, while the select pin follows its direction bit
	assign o_sck     = sck_drv;
	assign o_mosi    = out_bit;
	assign o_miso    = out_bit;
	assign o_ss      = pin_cfg[`SPM_PIN_SS_LVL];
	assign o_sck_oe  = is_master & pin_cfg[`SPM_PIN_SCK_DIR];
	assign o_mosi_oe = is_master & pin_cfg[`SPM_PIN_MOSI_DIR];
	assign o_miso_oe = slave_act & pin_cfg[`SPM_PIN_MISO_DIR];
	// the select pin is a plain output in master role when its direction bit is set, input in slave role
	assign o_ss_oe   = pin_cfg[`SPM_PIN_SS_DIR] & ~(en & ~master_select_bit);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	a_irq_gate: assert property (ie && transfer_done_flag && i_global_irq_en |-> o_irq)
		else $error("irq not raised with all gates set");
	a_forced_slave: assert property (force_slave |=> !master_select_bit && transfer_done_flag)
		else $error("select low did not force slave role");
	a_ss_reset: assert property (ss_rise |=> bit_cnt == 4'h0 && state == SPM_IDLE)
		else $error("select rise did not reset slave logic");
	a_passive_slave: assert property (en && !master_select_bit && ss_f |-> !o_miso_oe && !o_sck_oe)
		else $error("deselected slave drives a pin");
	a_miso_owner: assert property (o_miso_oe |-> en && !master_select_bit && !ss_f)
		else $error("miso driven outside selected slave");
	a_port_off: assert property (!en |-> !o_sck_oe && !o_mosi_oe ##1 state == SPM_IDLE)
		else $error("disabled port still active");
	a_write_collision_flag_set: assert property (data_wr && busy |=> write_collision_flag)
		else $error("collision flag not set");
	a_done_flag: assert property (done_ev |=> transfer_done_flag && state == SPM_IDLE)
		else $error("byte end did not set done flag");
	a_status_zero: assert property (i_psel && !i_penable && hit_sts |=> o_prdata[5:1] == 5'h00)
		else $error("reserved status bits not zero");
	a_sck_idle: assert property (is_master && !busy |=> ##1 (busy || o_sck == $past(clock_idle_level)))
		else $error("sck not at idle level");
	a_start_shift: assert property (start |=> busy ##1 (busy [*1]))
		else $error("data write did not start transfer");

endmodule

// *** spm_map.svh ***
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// register byte offsets on the APB window
`define SPM_OFF_CONTROL  12'h000
`define SPM_OFF_STATUS   12'h004
`define SPM_OFF_DATA     12'h008
`define SPM_OFF_PINCFG   12'h00c

// reset values
`define SPM_CTL_RESET    8'h00
`define SPM_STS_RESET    8'h00
`define SPM_PIN_RESET    8'h00
// pin filters start at {select, sck, mosi, miso} idle levels so no false edge follows reset
`define SPM_PIN_IDLE     4'h8

// port_control_reg fields
`define SPM_CTL_IE       7
`define SPM_CTL_EN       6
`define SPM_CTL_ORDER    5
`define SPM_CTL_MASTER   4
`define SPM_CTL_CLOCK_IDLE_LEVEL     3
`define SPM_CTL_CLOCK_PHASE_SELECT     2
`define SPM_CTL_RATE_HI  1
`define SPM_CTL_RATE_LO  0

// port_status_reg fields
`define SPM_STS_DONE     7
`define SPM_STS_WRITE_COLLISION_FLAG     6
`define SPM_STS_X2       0

// pin direction register fields
`define SPM_PIN_MOSI_DIR 0
`define SPM_PIN_MISO_DIR 1
`define SPM_PIN_SCK_DIR  2
`define SPM_PIN_SS_DIR   3
`define SPM_PIN_SS_LVL   4

// half periods of sck in system clocks, indexed by {double, rate_hi, rate_lo}
`define SPM_HALF_DIV4    7'd2
`define SPM_HALF_DIV16   7'd8
`define SPM_HALF_DIV64   7'd32
`define SPM_HALF_DIV128  7'd64
`define SPM_HALF_DIV2    7'd1
`define SPM_HALF_DIV8    7'd4
`define SPM_HALF_DIV32   7'd16
`define SPM_HALF_DIV64X  7'd32

// index of the last of the 16 sck edges in one byte, index of the last of the 8 bits in one byte
`define SPM_LAST_EDGE    5'd15
`define SPM_LAST_BIT     4'd7

`endif

// *** spm_pkg.sv ***
package spm_pkg;

	typedef enum logic [1:0] {
		SPM_IDLE  = 2'b01,
		SPM_SHIFT = 2'b10
	} spm_state_t;

	typedef logic [7:0] spm_byte_t;

endpackage

// *** spm_far_model.sv ***
`timescale 1ns/1ps
module spm_far_model (
	input  wire logic       i_clk,
	input  wire logic       i_sck,
	input  wire logic       i_mosi,
	input  wire logic       i_miso,
	input  wire logic       i_ss,
	input  wire logic       i_lsb,
	input  wire logic       i_clock_idle_level,
	input  wire logic       i_clock_phase_select,
	input  wire logic [7:0] i_tx,
	output logic      [7:0] o_rx,
	output logic      [7:0] o_mrx,
	output logic            o_sck,
	output logic            o_mosi,
	output logic            o_miso,
	output logic            o_ss
);
	logic tog    = 1'b0;
	logic sck_q  = 1'b0;
	logic frame  = 1'b0;
	logic mosi_v = 1'b0;
	int   s      = 0;
	int   idx;

	initial begin
		o_sck = 1'b0;
		o_ss  = 1'b1;
	end

	// a released line shows a level that changes every cycle, never the last bit
	always @(posedge i_clk) begin
		tog <= ~tog;
	end

	assign idx    = (s == 0) ? 0 : ((s > 7) ? 7 : s - int'(i_clock_phase_select));
	assign o_miso = i_ss ? tog : (i_lsb ? i_tx[idx] : i_tx[7 - idx]);
	assign o_mosi = frame ? mosi_v : tog;

	always @(i_sck or i_ss) begin
		if (i_ss) begin
			s = 0;
		end else if (i_sck !== sck_q) begin
			if ((i_sck != i_clock_idle_level) != i_clock_phase_select) begin
				o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
			end else begin
				s = s + 1;
			end
		end
		sck_q = i_sck;
	end

	// levels of eight system clocks keep well inside what the port can follow
	task automatic drive(input logic [7:0] b, input int n, input logic sel);
		int k;
		frame <= 1'b1;
		o_ss  <= ~sel;
		for (k = 0; k < n; k++) begin
			mosi_v <= b[7 - k];
			repeat (8) @(posedge i_clk);
			o_sck  <= 1'b1;
			o_mrx  <= {o_mrx[6:0], i_miso};
			repeat (8) @(posedge i_clk);
			o_sck  <= 1'b0;
		end
		repeat (8) @(posedge i_clk);
		o_ss  <= 1'b1;
		frame <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

// *** test_spi_master_slave_port.sv ***
`timescale 1ns/1ps
`include "spm_map.svh"
module test_spi_master_slave_port
	import spm_pkg::*;
;
	logic        clk    = 1'b0;
	logic        rstn   = 1'b0;
	logic        psel   = 1'b0;
	logic        pen    = 1'b0;
	logic        pwr    = 1'b0;
	logic [11:0] paddr  = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        gie    = 1'b0;
	logic        ack    = 1'b0;
	logic        lsb    = 1'b0;
	logic        clock_idle_level   = 1'b0;
	logic        clock_phase_select   = 1'b0;
	logic        err;
	logic        sck_q  = 1'b0;
	spm_byte_t   ftx    = 8'h00;
	spm_byte_t   frx, fmrx;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, ss, ss_oe;
	logic        f_sck, f_mosi, f_miso, f_ss;
	int          errors = 0, n_tests = 0, cyc = 0, first = -1, last = 0, ntog = 0;
	wire logic   sck_p  = sck_oe ? sck : f_sck;
	wire logic   mosi_p = mosi_oe ? mosi : f_mosi;
	wire logic   miso_p = miso_oe ? miso : f_miso;
	wire logic   ss_p   = ss_oe ? ss : f_ss;

	spm_port spm_port_i (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_global_irq_en(gie),
		.i_irq_ack(ack), .o_irq(irq), .i_sck(sck_p), .o_sck(sck), .o_sck_oe(sck_oe),
		.i_mosi(mosi_p), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_miso(miso_p), .o_miso(miso),
		.o_miso_oe(miso_oe), .i_ss(ss_p), .o_ss(ss), .o_ss_oe(ss_oe));

	spm_far_model spm_far_model_i (.i_clk(clk), .i_sck(sck_p), .i_mosi(mosi_p),
		.i_miso(miso_p), .i_ss(ss_p), .i_lsb(lsb), .i_clock_idle_level(clock_idle_level), .i_clock_phase_select(clock_phase_select), .i_tx(ftx),
		.o_rx(frx), .o_mrx(fmrx), .o_sck(f_sck), .o_mosi(f_mosi), .o_miso(f_miso), .o_ss(f_ss));

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (sck !== sck_q) begin
			if (first < 0) first = cyc;
			last = cyc;
			ntog = ntog + 1;
		end
		sck_q = sck;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic to(input string what);
		errors++;
		$display("mismatch %s expected response seen none", what);
		print_verdict;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input spm_byte_t d,
		output spm_byte_t q);
		int k;
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q   = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (k >= 20) to("pready");
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input spm_byte_t d);
		spm_byte_t q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input spm_byte_t exp);
		spm_byte_t q;
		apb(1'b0, a, 8'h00, q);
		chk(what, {8'h00, exp}, {8'h00, q});
	endtask

	function automatic int half(input logic [2:0] r);
		int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
		return dv[r] / 2;
	endfunction

	task automatic wait_done;
		spm_byte_t q;
		int k;
		q = 8'h00;
		for (k = 0; k < 1000 && q[7] !== 1'b1; k++)
			apb(1'b0, `SPM_OFF_STATUS, 8'h00, q);
		if (q[7] !== 1'b1) to("done flag");
	endtask

	task automatic mstart(input spm_byte_t ctl, input spm_byte_t b, input spm_byte_t sb);
		ftx  <= sb;
		lsb  <= ctl[5];
		clock_idle_level <= ctl[3];
		clock_phase_select <= ctl[2];
		wr(`SPM_OFF_PINCFG, 8'h1d);
		wr(`SPM_OFF_CONTROL, ctl);
		wr(`SPM_OFF_PINCFG, 8'h0d);
		first = -1;
		ntog  = 0;
		wr(`SPM_OFF_DATA, b);
	endtask

	initial begin
		spm_byte_t b, sb, q;
		spm_byte_t ctl;
		int i;
		void'($urandom(82049));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rdc("control reset", `SPM_OFF_CONTROL, 8'h00);
		wr(`SPM_OFF_STATUS, 8'hff);
		rdc("status bits", `SPM_OFF_STATUS, 8'h01);
		wr(`SPM_OFF_STATUS, 8'h00);
		apb(1'b0, 12'h010, 8'h00, q);
		chk("unmapped", 16'h0100, {7'h0, err, q});
		wr(`SPM_OFF_PINCFG, 8'h0d);
		wr(`SPM_OFF_CONTROL, 8'h10);
		ntog = 0;
		wr(`SPM_OFF_DATA, 8'ha5);
		repeat (200) @(posedge clk);
		chk("disabled sck", 16'h0, {ntog[14:0], sck_oe});
		rdc("disabled flag", `SPM_OFF_STATUS, 8'h00);
		$display("test registers and enable done");
		for (i = 0; i < 8; i++) begin
			b   = 8'($urandom);
			sb  = 8'($urandom);
			gie <= 1'($urandom);
			ctl = {2'b11, i[2], 1'b1, i[1:0], 2'b01};
			mstart(ctl, b, sb);
			chk("ss output", 16'h0, {15'h0, ss});
			wait_done;
			chk("irq", {15'h0, gie}, {15'h0, irq});
			if (i[0]) begin
				ack <= 1'b1;
				@(posedge clk);
				ack <= 1'b0;
				rdc("ack clears", `SPM_OFF_STATUS, 8'h00);
			end
			rdc("rx byte", `SPM_OFF_DATA, sb);
			rdc("flag cleared", `SPM_OFF_STATUS, 8'h00);
			chk("far rx", {8'h0, b}, {8'h0, frx});
			chk("toggles", 16'd16, ntog[15:0]);
			chk("sck idle", {15'h0, ctl[3]}, {15'h0, sck});
			rdc("still master", `SPM_OFF_CONTROL, ctl);
		end
		$display("test modes done");
		for (i = 0; i < 8; i++) begin
			wr(`SPM_OFF_STATUS, {7'h0, i[2]});
			mstart({6'h14, i[1:0]}, 8'h3c, 8'h00);
			wait_done;
			chk("sck span", 16'(15 * half(i[2:0])), 16'(last - first));
			apb(1'b0, `SPM_OFF_DATA, 8'h00, q);
		end
		wr(`SPM_OFF_STATUS, 8'h00);
		$display("test rates done");
		mstart(8'h51, 8'h96, 8'h69);
		wr(`SPM_OFF_DATA, 8'h5a);
		rdc("collision", `SPM_OFF_STATUS, 8'h40);
		wait_done;
		rdc("first kept", `SPM_OFF_DATA, 8'h69);
		rdc("both cleared", `SPM_OFF_STATUS, 8'h00);
		chk("far rx", 16'h0096, {8'h0, frx});
		$display("test collision done");
		wr(`SPM_OFF_PINCFG, 8'h05);
		wr(`SPM_OFF_CONTROL, 8'h50);
		spm_far_model_i.drive(8'h00, 0, 1'b1);
		rdc("master dropped", `SPM_OFF_CONTROL, 8'h40);
		chk("outputs released", 16'h0, {14'h0, sck_oe, mosi_oe});
		rdc("drop flag", `SPM_OFF_STATUS, 8'h80);
		apb(1'b0, `SPM_OFF_DATA, 8'h00, q);
		wr(`SPM_OFF_CONTROL, 8'h50);
		rdc("master again", `SPM_OFF_CONTROL, 8'h50);
		$display("test fallback done");
		lsb  <= 1'b0;
		clock_idle_level <= 1'b0;
		clock_phase_select <= 1'b0;
		wr(`SPM_OFF_PINCFG, 8'h02);
		wr(`SPM_OFF_CONTROL, 8'h40);
		b  = 8'($urandom);
		sb = 8'($urandom);
		wr(`SPM_OFF_DATA, b);
		fork
			spm_far_model_i.drive(sb, 8, 1'b1);
			begin
				repeat (30) @(posedge clk);
				chk("slave pins", 16'h1, {12'h0, sck_oe, mosi_oe, ss_oe, miso_oe});
			end
		join
		chk("miso released", 16'h0, {15'h0, miso_oe});
		rdc("slave done", `SPM_OFF_STATUS, 8'h80);
		rdc("slave rx", `SPM_OFF_DATA, sb);
		chk("far got", {8'h0, b}, {8'h0, fmrx});
		spm_far_model_i.drive(8'hff, 3, 1'b1);
		spm_far_model_i.drive(8'h00, 8, 1'b0);
		rdc("no flag", `SPM_OFF_STATUS, 8'h00);
		sb = 8'($urandom);
		spm_far_model_i.drive(sb, 8, 1'b1);
		rdc("resync rx", `SPM_OFF_DATA, sb);
		$display("test slave done");
		print_verdict;
	end
endmodule
